/* rtl/bus_err_pkg.sv */
// constants and types for the bus error detect and addressing block
package bus_err_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_ERR    = 8'h00;
  localparam logic [7:0] OFS_UNIT   = 8'h04;
  localparam logic [7:0] OFS_SLAVE  = 8'h08;
  localparam logic [7:0] OFS_PART   = 8'h0C;
  localparam logic [7:0] OFS_BUF    = 8'h10;
  localparam logic [7:0] OFS_CTRL   = 8'h14;
  localparam logic [7:0] OFS_STAT   = 8'h18;
  // error_cause_flags bit positions
  localparam int B_WIDTH = 7;
  localparam int B_PAR   = 6;
  localparam int B_NACK  = 5;
  localparam int B_STARV = 4;
  localparam int B_OVF   = 3;
  localparam int B_UNSNT = 2;
  localparam int B_MON   = 0;
  localparam logic [7:0] ERR_MASK = 8'hFD;
  // link_control_register bits
  localparam int B_LINK_EN = 0;
  localparam int B_SRX_EN  = 1;
  // status register bits
  localparam int B_SUMMARY = 0;
  localparam int B_OVF_ST  = 1;
  localparam int B_MONITOR = 2;
  localparam int B_BUFFULL = 3;
  // reset values
  localparam logic [7:0]  RST_ERR  = 8'h00;
  localparam logic [11:0] RST_ADDR = 12'h000;
  localparam logic [7:0]  RST_BUF  = 8'h00;
  // special addresses and control codes
  localparam logic [11:0] ALL_UNITS = 12'hFFF;
  localparam logic [3:0]  CODE_WRITE_DATA = 4'hF;
  // frame field being reported by the bit engine
  typedef enum logic [2:0] {
    FLD_MASTER = 3'b000,
    FLD_SLAVE  = 3'b001,
    FLD_CTRL   = 3'b010,
    FLD_LEN    = 3'b011,
    FLD_DATA   = 3'b100
  } field_e;
endpackage

/* rtl/bus_err_detect.sv */
// error detection, error flags and address registers of the serial bus controller
// Contract
// RULE1: bit width fault sets flag bit 7.
// RULE2: a bit width fault pulses error and combined status interrupts.
// RULE3: parity mismatch sets bit 6; individual data field returns nack instead. The code sets no flag for a transmitter that is not monitoring.
// RULE4: individual nack on slave, control or length acknowledge sets bit 5.
// RULE5: data field nack retransmits silently; at maximum byte count it errors.
// RULE6: no nack error in broadcast or while monitoring third parties.
// RULE7: transmit byte missing at acknowledge sets bit 4, except individual nack.
// RULE8: stored receive byte requests data; unread buffer on next byte sets bit 3.
// RULE9: overflow state lasts until buffer read or reset, beyond frame end.
// RULE10: pending overflow suppresses transmit data requests.
// RULE11: individual overflow returns nack so the sender retransmits.
// RULE12: broadcast overflow interrupts, stops reception, keeps buffer and receiving state.
// RULE13: written byte left unsent in own transmission sets bit 2.
// RULE14: width or parity fault while monitoring sets bit 0.
// RULE15: faults before monitoring begins leave bit 0 clear.
// RULE16: mismatched slave address with acknowledge continuing starts third party monitoring.
// RULE17: unservable broadcast write code monitors; individual returns nack and ends.
// RULE18: own unit address is 12 bits, frozen while link enabled.
// RULE19: target slave address, 12 bits, goes out in slave address field.
// RULE20: received master address is captured into read-only partner register.
// RULE21: partner capture only with good parity and unit unlocked.
// RULE22: software copies partner address bytes into buffer for lock requests.
// RULE23: error bits clear only by writing zero; ones written are ignored.
// RULE24: each error bit sets the summary fault flag too; the code leaves it clear for an individual overflow (bit 3).
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module bus_err_detect #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // bit engine events
  input  wire logic              bit_width_fault,
  input  wire logic              parity_check,
  input  wire logic              parity_ok,
  input  wire logic [2:0]        check_field,
  input  wire logic [ADDR_W-1:0] field_value,
  input  wire logic              ack_seen,
  input  wire logic              ack_is_nack,
  input  wire logic              rx_byte_valid,
  input  wire logic [7:0]        rx_byte,
  input  wire logic              tx_byte_taken,
  input  wire logic              frame_end,
  // bit engine levels
  input  wire logic              broadcast_mode,
  input  wire logic              is_transmitter,
  input  wire logic              at_max_bytes,
  input  wire logic              tx_more,
  input  wire logic              unit_locked,
  // to the bit engine and cpu side
  output logic [ADDR_W-1:0]      target_slave_address,
  output logic [7:0]             tx_byte,
  output logic                   buffer_full,
  output logic                   link_enable_bit,
  output logic                   monitoring,
  output logic                   return_nack,
  output logic                   stop_reception,
  output logic                   summary_comm_fault_flag,
  output logic                   error_irq,
  output logic                   combined_status_irq,
  output logic                   data_request_irq
);
  // the register map packs every address into 12 bits
  if (ADDR_W != 12) begin : g_width_check
    $error("address width must be 12");
  end

  // whole state in one record, registered by one flop bank
  typedef struct packed {
    logic [7:0]        flags;
    logic              summary;
    logic [ADDR_W-1:0] unit;
    logic [ADDR_W-1:0] slave;
    logic [ADDR_W-1:0] partner;
    logic [ADDR_W-1:0] seen_slave;
    logic [7:0]        buf_data;
    logic              buf_full;
    logic              ovf;
    logic              link_en;
    logic              srx_en;
    logic              monitor;
    logic              err_irq;
    logic              comb_irq;
    logic              dreq_irq;
    logic              nack_ret;
    logic              rx_stop;
    logic              rdy;
    logic              err;
    logic [31:0]       rdata;
  } state_s;

  state_s s_q;
  state_s s_d;

  logic       acc;
  logic       wr;
  logic       rd;
  logic       hit;
  logic [7:0] set;
  logic [7:0] clr;
  logic       sum_set;
  logic       is_data;
  logic       bad_par;
  logic       slave_match;
  logic [31:0] rval;

  always_comb begin
    s_d         = s_q;
    set         = 8'h00;
    clr         = 8'h00;
    sum_set     = 1'b0;
    rval        = 32'h0000_0000;
    hit         = 1'b1;
    is_data     = (check_field == bus_err_pkg::FLD_DATA);
    bad_par     = parity_check && !parity_ok;
    s_d.err_irq  = 1'b0;
    s_d.comb_irq = 1'b0;
    s_d.dreq_irq = 1'b0;
    s_d.nack_ret = 1'b0;
    s_d.rx_stop  = 1'b0;

    // address match for the last slave address field seen
    if (broadcast_mode) begin
      slave_match = (s_q.seen_slave == bus_err_pkg::ALL_UNITS) ||
                    (s_q.seen_slave[ADDR_W-1:8] == s_q.unit[ADDR_W-1:8]); // [RULE16]
    end else begin
      slave_match = (s_q.seen_slave == s_q.unit); // [RULE16]
    end

    // apb decode; one wait state, action at the pready edge
    acc = psel && penable && s_q.rdy;
    wr  = acc && pwrite;
    rd  = acc && !pwrite;
    case (paddr)
      bus_err_pkg::OFS_ERR:   rval = {24'h000000, s_q.flags};
      bus_err_pkg::OFS_UNIT:  rval = {20'h00000, s_q.unit};
      bus_err_pkg::OFS_SLAVE: rval = {20'h00000, s_q.slave};
      bus_err_pkg::OFS_PART:  rval = {20'h00000, s_q.partner};
      bus_err_pkg::OFS_BUF:   rval = {24'h000000, s_q.buf_data};
      bus_err_pkg::OFS_CTRL:  rval = {30'h00000000, s_q.srx_en, s_q.link_en};
      bus_err_pkg::OFS_STAT:  rval = {28'h0000000, s_q.buf_full, s_q.monitor, s_q.ovf, s_q.summary};
      default: begin
        rval = 32'h0000_0000;
        hit  = 1'b0;
      end
    endcase
    s_d.rdy = psel && penable && !s_q.rdy;
    // answer captured in the wait state so prdata and pslverr leave a flop
    if (psel && penable && !s_q.rdy) begin
      s_d.rdata = pwrite ? 32'h0000_0000 : rval;
      s_d.err   = !hit;
    end else if (acc) begin
      s_d.rdata = 32'h0000_0000;
      s_d.err   = 1'b0;
    end

    // software writes
    // unit and slave addresses freeze while the link runs
    if (wr) begin
      case (paddr)
        bus_err_pkg::OFS_ERR: begin
          clr = ~pwdata[7:0] & bus_err_pkg::ERR_MASK; // [RULE23]
        end
        bus_err_pkg::OFS_UNIT: begin
          if (!s_q.link_en) begin
            s_d.unit = pwdata[ADDR_W-1:0]; // [RULE18]
          end
        end
        bus_err_pkg::OFS_SLAVE: begin
          if (!s_q.link_en) begin
            s_d.slave = pwdata[ADDR_W-1:0]; // [RULE19]
          end
        end
        bus_err_pkg::OFS_BUF: begin
          // lock address bytes are copied here by software [RULE22]
          s_d.buf_data = pwdata[7:0];
          s_d.buf_full = 1'b1;
        end
        bus_err_pkg::OFS_CTRL: begin
          s_d.link_en = pwdata[bus_err_pkg::B_LINK_EN];
          s_d.srx_en  = pwdata[bus_err_pkg::B_SRX_EN];
        end
        bus_err_pkg::OFS_STAT: begin
          if (!pwdata[bus_err_pkg::B_SUMMARY]) begin
            s_d.summary = 1'b0;
          end
        end
        default: begin
          s_d.unit = s_d.unit;
        end
      endcase
    end

    // reading the buffer empties it and ends the overflow state
    if (rd && paddr == bus_err_pkg::OFS_BUF) begin
      s_d.buf_full = 1'b0;
      s_d.ovf      = 1'b0; // [RULE9]
    end

    // bit width fault
    if (bit_width_fault) begin
      set[bus_err_pkg::B_WIDTH] = 1'b1; // [RULE1]
      sum_set = 1'b1;
      if (s_q.monitor) begin
        set[bus_err_pkg::B_MON] = 1'b1; // [RULE14]
      end
    end

    // parity results
    if (bad_par) begin
      if (is_data && !broadcast_mode && !is_transmitter && !s_q.monitor) begin
        s_d.nack_ret = 1'b1; // [RULE3]
      end else if (!is_transmitter || s_q.monitor) begin
        set[bus_err_pkg::B_PAR] = 1'b1; // [RULE3]
        sum_set = 1'b1;
        if (s_q.monitor) begin
          set[bus_err_pkg::B_MON] = 1'b1; // [RULE14]
        end
      end
    end
    if (parity_check && parity_ok) begin
      case (check_field)
        bus_err_pkg::FLD_MASTER: begin
          // a locked unit keeps the partner that holds the lock
          if (!unit_locked) begin
            s_d.partner = field_value; // [RULE20] [RULE21]
          end
        end
        bus_err_pkg::FLD_SLAVE: begin
          s_d.seen_slave = field_value;
        end
        bus_err_pkg::FLD_CTRL: begin
          if (!s_q.monitor && !is_transmitter && !s_q.srx_en &&
              field_value[3:0] == bus_err_pkg::CODE_WRITE_DATA) begin
            if (broadcast_mode) begin
              s_d.monitor = 1'b1; // [RULE17]
            end else begin
              s_d.nack_ret = 1'b1; // [RULE17]
            end
          end
        end
        default: begin
          s_d.seen_slave = s_d.seen_slave;
        end
      endcase
    end

    // acknowledge results
    if (ack_seen) begin
      if (ack_is_nack && !broadcast_mode && !s_q.monitor) begin // [RULE6]
        if (!is_data || at_max_bytes) begin
          set[bus_err_pkg::B_NACK] = 1'b1; // [RULE4] [RULE5] [RULE15]
          sum_set = 1'b1;
        end
      end
      if (check_field == bus_err_pkg::FLD_SLAVE && !ack_is_nack &&
          !slave_match && !is_transmitter) begin
        s_d.monitor = 1'b1; // [RULE16]
      end
      // an individual nack resends the old byte, so no underrun then
      if (is_data && is_transmitter && tx_more && !s_q.buf_full &&
          !(ack_is_nack && !broadcast_mode)) begin
        set[bus_err_pkg::B_STARV] = 1'b1; // [RULE7] [RULE10]
        sum_set = 1'b1;
      end
    end

    // received data byte
    // monitored traffic never touches the buffer
    if (rx_byte_valid && !s_q.monitor) begin
      if (s_q.buf_full) begin
        set[bus_err_pkg::B_OVF] = 1'b1; // [RULE8]
        s_d.ovf = 1'b1;
        if (broadcast_mode) begin
          s_d.rx_stop = 1'b1; // [RULE12]
          sum_set = 1'b1;
        end else begin
          // sender retransmits after the nack
          s_d.nack_ret = 1'b1; // [RULE11]
        end
      end else begin
        s_d.buf_data = rx_byte;
        s_d.buf_full = 1'b1;
        s_d.dreq_irq = 1'b1; // [RULE8]
      end
    end

    // transmit byte handed to the bit engine
    // pending overflow withholds the request; software must read the buffer first
    if (tx_byte_taken) begin
      s_d.buf_full = 1'b0;
      if (tx_more && !s_q.ovf) begin
        s_d.dreq_irq = 1'b1; // [RULE10]
      end
    end

    // frame end closes monitoring; overflow state survives it
    if (frame_end) begin
      s_d.monitor = 1'b0;
      if (is_transmitter && s_q.buf_full && !s_q.monitor) begin
        set[bus_err_pkg::B_UNSNT] = 1'b1; // [RULE13]
        sum_set = 1'b1;
        s_d.buf_full = 1'b0;
      end
    end

    // hardware set wins over a software clear in the same cycle
    s_d.flags = ((s_q.flags & ~clr) | set) & bus_err_pkg::ERR_MASK; // [RULE23]
    if (sum_set) begin
      s_d.summary  = 1'b1; // [RULE24]
      s_d.err_irq  = 1'b1; // [RULE2]
      s_d.comb_irq = 1'b1; // [RULE2]
    end
  end

  // reset branch loads constants only
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '{
        flags: bus_err_pkg::RST_ERR,
        summary: 1'b0,
        unit: bus_err_pkg::RST_ADDR,
        slave: bus_err_pkg::RST_ADDR,
        partner: bus_err_pkg::RST_ADDR,
        seen_slave: bus_err_pkg::RST_ADDR,
        buf_data: bus_err_pkg::RST_BUF,
        buf_full: 1'b0,
        ovf: 1'b0,
        link_en: 1'b0,
        srx_en: 1'b0,
        monitor: 1'b0,
        err_irq: 1'b0,
        comb_irq: 1'b0,
        dreq_irq: 1'b0,
        nack_ret: 1'b0,
        rx_stop: 1'b0,
        rdy: 1'b0,
        err: 1'b0,
        rdata: 32'h0000_0000
      };
    end else begin
      s_q <= s_d;
    end
  end

  // every output is a plain flop of the state record
  assign prdata                  = s_q.rdata;
  assign pready                  = s_q.rdy;
  assign pslverr                 = s_q.err;
  assign target_slave_address    = s_q.slave; // [RULE19]
  assign tx_byte                 = s_q.buf_data;
  assign buffer_full             = s_q.buf_full;
  assign link_enable_bit         = s_q.link_en;
  assign monitoring              = s_q.monitor;
  assign return_nack             = s_q.nack_ret;
  assign stop_reception          = s_q.rx_stop;
  assign summary_comm_fault_flag = s_q.summary;
  assign error_irq               = s_q.err_irq;
  assign combined_status_irq     = s_q.comb_irq;
  assign data_request_irq        = s_q.dreq_irq;
endmodule // bus_err_detect

/* bench/bus_err_monitor.sv */
// assertion checker for the bus error detect block
`timescale 1ns/1ps
module bus_err_monitor (
  // clock, reset and apb handshake
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  // engine events and levels
  input wire logic       bit_width_fault,
  input wire logic       parity_check,
  input wire logic       parity_ok,
  input wire logic [2:0] check_field,
  input wire logic       ack_seen,
  input wire logic       ack_is_nack,
  input wire logic       rx_byte_valid,
  input wire logic       frame_end,
  input wire logic       broadcast_mode,
  input wire logic       is_transmitter,
  // block outputs
  input wire logic       buffer_full,
  input wire logic       monitoring,
  input wire logic       return_nack,
  input wire logic       stop_reception,
  input wire logic       summary_comm_fault_flag,
  input wire logic       error_irq,
  input wire logic       combined_status_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_width_irq: assert property (bit_width_fault |=> error_irq && combined_status_irq)
    else $error("width fault without both interrupts");
  a_fault_summary: assert property ($rose(summary_comm_fault_flag) |-> error_irq && combined_status_irq)
    else $error("summary rose without interrupts");
  a_data_parity: assert property (parity_check && !parity_ok && check_field == 3'd4 && !broadcast_mode
    && !monitoring && !is_transmitter |=> return_nack) else $error("data parity fault without nack");
  a_bcast_quiet: assert property (ack_seen && broadcast_mode && check_field != 3'd4 && !bit_width_fault
    && !parity_check && !rx_byte_valid && !summary_comm_fault_flag |=> !summary_comm_fault_flag)
    else $error("broadcast acknowledge raised a fault");
  a_ovf_nack: assert property (rx_byte_valid && buffer_full && !broadcast_mode && !monitoring |=> return_nack)
    else $error("individual overflow without nack");
  a_ovf_stop: assert property (rx_byte_valid && buffer_full && broadcast_mode && !monitoring
    |=> stop_reception && error_irq) else $error("broadcast overflow did not stop");
  a_nack_no_mon: assert property (ack_seen && ack_is_nack && check_field == 3'd1 && !monitoring
    && !parity_check |=> !monitoring) else $error("nack started monitoring");
  a_mon_end: assert property (frame_end |=> !monitoring)
    else $error("monitoring outlived frame end");
  a_ready_wait: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb wait state wrong");
endmodule // bus_err_monitor

bind bus_err_detect bus_err_monitor bus_err_monitor_inst (
  .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pready(pready),
  .bit_width_fault(bit_width_fault), .parity_check(parity_check), .parity_ok(parity_ok),
  .check_field(check_field), .ack_seen(ack_seen), .ack_is_nack(ack_is_nack), .rx_byte_valid(rx_byte_valid),
  .frame_end(frame_end), .broadcast_mode(broadcast_mode), .is_transmitter(is_transmitter),
  .buffer_full(buffer_full), .monitoring(monitoring),
  .return_nack(return_nack), .stop_reception(stop_reception), .summary_comm_fault_flag(summary_comm_fault_flag),
  .error_irq(error_irq), .combined_status_irq(combined_status_irq)
);

/* bench/bus_peer.sv */
// far side model: bit engine events and bus levels
`timescale 1ns/1ps
module bus_peer (
  // clock
  input  wire logic   clk,
  // pulses and qualifiers
  output logic        bit_width_fault, parity_check, ack_seen, rx_byte_valid, tx_byte_taken, frame_end,
  output logic        parity_ok, ack_is_nack,
  output logic [2:0]  check_field,
  output logic [11:0] field_value,
  output logic [7:0]  rx_byte,
  // levels
  output logic        broadcast_mode, is_transmitter, at_max_bytes, tx_more, unit_locked
);
  initial begin
    {bit_width_fault, parity_check, ack_seen, rx_byte_valid, tx_byte_taken, frame_end} = '0;
    {parity_ok, ack_is_nack, check_field, field_value, rx_byte} = '0;
    {broadcast_mode, is_transmitter, at_max_bytes, tx_more, unit_locked} = '0;
  end
  // ok means good parity or a positive acknowledge; qualifiers hold past the pulse
  task automatic ev(input logic [5:0] p, input logic [2:0] f, input logic ok, input logic [11:0] v);
    @(posedge clk);
    {bit_width_fault, parity_check, ack_seen, rx_byte_valid, tx_byte_taken, frame_end} <= p;
    check_field <= f;
    parity_ok <= ok;
    ack_is_nack <= !ok;
    field_value <= v;
    rx_byte <= v[7:0];
    @(posedge clk);
    {bit_width_fault, parity_check, ack_seen, rx_byte_valid, tx_byte_taken, frame_end} <= '0;
  endtask
  task automatic lv(input logic [4:0] l);
    @(posedge clk);
    {broadcast_mode, is_transmitter, at_max_bytes, tx_more, unit_locked} <= l;
  endtask
endmodule // bus_peer

/* bench/tb_top.sv */
// self-checking bench for the bus error detect block
`timescale 1ns/1ps
module tb_top;
  localparam logic [5:0] WF = 6'h20, PC = 6'h10, AK = 6'h08, RX = 6'h04, TK = 6'h02, FE = 6'h01;
  logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr, tx_byte, rx_byte;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] field_value, target_slave_address;
  logic [2:0]  check_field;
  logic        bit_width_fault, parity_check, parity_ok, ack_seen, ack_is_nack, rx_byte_valid, tx_byte_taken;
  logic        frame_end, broadcast_mode, is_transmitter, at_max_bytes, tx_more, unit_locked, buffer_full;
  logic        link_enable_bit, monitoring, return_nack, stop_reception, summary_comm_fault_flag;
  logic        error_irq, combined_status_irq, data_request_irq;
  int          fail_count, compares;
  bus_err_detect #(.ADDR_W(12)) bus_err_detect_inst (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bit_width_fault(bit_width_fault), .parity_check(parity_check), .parity_ok(parity_ok),
    .check_field(check_field), .field_value(field_value), .ack_seen(ack_seen), .ack_is_nack(ack_is_nack),
    .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .tx_byte_taken(tx_byte_taken), .frame_end(frame_end),
    .broadcast_mode(broadcast_mode), .is_transmitter(is_transmitter), .at_max_bytes(at_max_bytes),
    .tx_more(tx_more), .unit_locked(unit_locked), .target_slave_address(target_slave_address),
    .tx_byte(tx_byte), .buffer_full(buffer_full), .link_enable_bit(link_enable_bit), .monitoring(monitoring),
    .return_nack(return_nack), .stop_reception(stop_reception),
    .summary_comm_fault_flag(summary_comm_fault_flag), .error_irq(error_irq),
    .combined_status_irq(combined_status_irq), .data_request_irq(data_request_irq)
  );
  bus_peer bus_peer_inst (
    .clk(clk), .bit_width_fault(bit_width_fault), .parity_check(parity_check), .ack_seen(ack_seen),
    .rx_byte_valid(rx_byte_valid), .tx_byte_taken(tx_byte_taken), .frame_end(frame_end), .parity_ok(parity_ok),
    .ack_is_nack(ack_is_nack), .check_field(check_field), .field_value(field_value), .rx_byte(rx_byte),
    .broadcast_mode(broadcast_mode), .is_transmitter(is_transmitter), .at_max_bytes(at_max_bytes),
    .tx_more(tx_more), .unit_locked(unit_locked)
  );
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // waits for pready however long; only the watchdog ends a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, rd, e);
  endtask
  task automatic clr;
    apb(1'b1, bus_err_pkg::OFS_ERR, 32'h0);
    apb(1'b1, bus_err_pkg::OFS_STAT, 32'h0);
  endtask
  task automatic ef(input string n, input logic [31:0] e);
    rc(n, bus_err_pkg::OFS_ERR, e);
    clr;
  endtask
  task automatic t_width;
    for (int i = 0; i < 4; i++) rc("reset value", 8'(4 * i), 32'h0);
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped slverr", {31'h0, err}, 32'h1);
    bus_peer_inst.ev(WF, 3'd0, 1'b1, 12'h0);
    rc("width flag", bus_err_pkg::OFS_ERR, 32'h80);
    rc("summary", bus_err_pkg::OFS_STAT, 32'h1);
    apb(1'b1, bus_err_pkg::OFS_ERR, 32'hFF);
    rc("write one", bus_err_pkg::OFS_ERR, 32'h80);
    clr;
    ef("write zero", 32'h0);
  endtask
  task automatic t_fields;
    for (int m = 0; m < 2; m++) begin
      bus_peer_inst.lv({1'(m), 4'b0000});
      for (int f = 0; f < 5; f++) begin
        bus_peer_inst.ev(PC, 3'(f), 1'b0, 12'h0);
        ef("parity flag", (f == 4 && m == 0) ? 32'h0 : 32'h40);
      end
      bus_peer_inst.lv({1'(m), 4'b1010});
      for (int f = 1; f < 5; f++) begin
        bus_peer_inst.ev(AK, 3'(f), 1'b0, 12'h0);
        ef("nack flag", m == 0 ? (f < 4 ? 32'h20 : 32'h0) : (f == 4 ? 32'h10 : 32'h0));
      end
    end
    bus_peer_inst.lv(5'b01110);
    bus_peer_inst.ev(AK, 3'd4, 1'b0, 12'h0);
    ef("nack at max", 32'h20);
    bus_peer_inst.lv(5'b01010);
    bus_peer_inst.ev(AK, 3'd4, 1'b1, 12'h0);
    ef("underrun", 32'h10);
    apb(1'b1, bus_err_pkg::OFS_BUF, 32'h5A);
    bus_peer_inst.ev(FE, 3'd0, 1'b1, 12'h0);
    ef("unsent write", 32'h04);
    bus_peer_inst.ev(TK, 3'd0, 1'b1, 12'h0);
    #1;
    chk("tx request", {31'h0, data_request_irq}, 32'h1);
  endtask
  task automatic t_ovf;
    bus_peer_inst.lv(5'b00000);
    bus_peer_inst.ev(RX, 3'd0, 1'b1, 12'h011);
    #1;
    chk("rx request", {31'h0, data_request_irq}, 32'h1);
    bus_peer_inst.ev(RX, 3'd0, 1'b1, 12'h022);
    bus_peer_inst.ev(FE, 3'd0, 1'b1, 12'h0);
    rc("overflow kept", bus_err_pkg::OFS_STAT, 32'hA);
    rc("buffer kept", bus_err_pkg::OFS_BUF, 32'h11);
    rc("overflow gone", bus_err_pkg::OFS_STAT, 32'h0);
    ef("overflow flag", 32'h08);
    bus_peer_inst.lv(5'b10000);
    bus_peer_inst.ev(RX, 3'd0, 1'b1, 12'h033);
    bus_peer_inst.ev(RX, 3'd0, 1'b1, 12'h044);
    rc("broadcast status", bus_err_pkg::OFS_STAT, 32'hB);
    bus_peer_inst.lv(5'b11010);
    bus_peer_inst.ev(TK, 3'd0, 1'b1, 12'h0);
    #1;
    chk("no tx request", {31'h0, data_request_irq}, 32'h0);
    rc("broadcast buffer", bus_err_pkg::OFS_BUF, 32'h33);
    ef("broadcast overflow", 32'h08);
  endtask
  // third party watch: slave field events and an optional control code event, then a check of the monitor state
  task automatic mon(input logic [4:0] l, input logic [11:0] a, input logic k, input logic c, input logic e);
    bus_peer_inst.lv(l);
    bus_peer_inst.ev(PC, 3'd1, 1'b1, a);
    bus_peer_inst.ev(AK, 3'd1, k, 12'h0);
    if (c) bus_peer_inst.ev(PC, 3'd2, 1'b1, 12'h00F);
    #1;
    chk("monitoring", {31'h0, monitoring}, {31'h0, e});
  endtask
  task automatic t_mon;
    apb(1'b1, bus_err_pkg::OFS_UNIT, 32'h123);
    mon(5'b00000, 12'h456, 1'b0, 1'b0, 1'b0);
    ef("nack first", 32'h20);
    mon(5'b00000, 12'h456, 1'b1, 1'b0, 1'b1);
    bus_peer_inst.ev(WF, 3'd0, 1'b1, 12'h0);
    ef("monitor fault", 32'h81);
    bus_peer_inst.ev(FE, 3'd0, 1'b1, 12'h0);
    mon(5'b00000, 12'h123, 1'b1, 1'b0, 1'b0);
    mon(5'b10000, 12'hFFF, 1'b1, 1'b1, 1'b1);
    bus_peer_inst.ev(FE, 3'd0, 1'b1, 12'h0);
    mon(5'b00000, 12'h123, 1'b1, 1'b1, 1'b0);
    chk("code refused", {31'h0, return_nack}, 32'h1);
    bus_peer_inst.ev(FE, 3'd0, 1'b1, 12'h0);
    clr;
  endtask
  task automatic t_addr;
    apb(1'b1, bus_err_pkg::OFS_SLAVE, 32'hABC);
    apb(1'b1, bus_err_pkg::OFS_CTRL, 32'h1);
    apb(1'b1, bus_err_pkg::OFS_UNIT, 32'h777);
    apb(1'b1, bus_err_pkg::OFS_SLAVE, 32'h555);
    rc("unit frozen", bus_err_pkg::OFS_UNIT, 32'h123);
    chk("slave out", {20'h0, target_slave_address}, 32'hABC);
    chk("link on", {31'h0, link_enable_bit}, 32'h1);
    apb(1'b1, bus_err_pkg::OFS_CTRL, 32'h0);
    bus_peer_inst.ev(PC, 3'd0, 1'b1, 12'h9C5);
    bus_peer_inst.lv(5'b00001);
    bus_peer_inst.ev(PC, 3'd0, 1'b1, 12'h111);
    bus_peer_inst.lv(5'b00000);
    bus_peer_inst.ev(PC, 3'd0, 1'b0, 12'h222);
    apb(1'b1, bus_err_pkg::OFS_PART, 32'h333);
    rc("partner", bus_err_pkg::OFS_PART, 32'h9C5);
    apb(1'b1, bus_err_pkg::OFS_BUF, {24'h0, rd[7:0]});
    #1;
    chk("lock copy", {24'h0, tx_byte}, 32'hC5);
    ef("master parity", 32'h40);
  endtask
  task automatic complete_run;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    fail_count = 0;
    compares = 0;
    sys_rst = 1'b1;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    t_width;
    t_fields;
    t_ovf;
    t_mon;
    t_addr;
    complete_run;
  end
  initial begin
    #40000;
    fail_count++;
    complete_run;
  end
endmodule // tb_top
